/* File: hdl/pcs_pkg.sv */
/*
 Package for the PC Card socket control block: cycle kinds, battery states,
 request and status carriers, strobe timing counts.
 Assumes a single 40 MHz system clock.
*/
package pcs_pkg;
    // Clock and strobe timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int STROBE_NS = 165;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_NS = 70;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
    localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);

    // Battery condition codes
    typedef enum logic [1:0] {
        PCS_BATT_GOOD = 2'h0,
        PCS_BATT_WEAK = 2'h1,
        PCS_BATT_DEAD = 2'h2
    } pcs_batt_t;

    // Kind of card cycle requested by the host side
    typedef enum logic [1:0] {
        PCS_CYC_IO_RD = 2'h0,
        PCS_CYC_IO_WR = 2'h1,
        PCS_CYC_DMA_TO_HOST = 2'h2,
        PCS_CYC_DMA_TO_CARD = 2'h3
    } pcs_cyc_t;

    // Host request: kind and which bytes are wanted
    typedef struct packed {
        pcs_cyc_t kind;
        logic even_byte;
        logic odd_byte;
    } pcs_req_t;

    // Socket status seen by software
    typedef struct packed {
        logic card_inserted;
        logic card_present_a;
        logic card_present_b;
        pcs_batt_t batt;
    } pcs_status_t;

    // Reset values of the socket strobes (all deasserted high)
    localparam logic STROBE_IDLE = 1'h1;
endpackage

/* File: hdl/pcs_status.sv */
/*
 Socket status tracker: decodes battery lines and card detect, raises a
 status-change pulse on enabled battery changes.
 Assumes socket inputs already synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module pcs_status
    import pcs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Socket pins
    input wire logic battery_detect_a_i,
    input wire logic battery_detect_b_i,
    input wire logic card_present_a_i,
    input wire logic card_present_b_i,
    // Control
    input wire logic batt_dead_chg_en_i,
    input wire logic batt_weak_chg_en_i,
    // Results
    output pcs_status_t status_o,
    output logic status_chg_o
);
    pcs_batt_t next_batt;

    // Battery decode: line a low means dead, else line b low means weak
    always_comb begin
        if (!battery_detect_a_i) begin
            next_batt = PCS_BATT_DEAD; // see [RULE1]
        end else if (!battery_detect_b_i) begin
            next_batt = PCS_BATT_WEAK; // see [RULE1]
        end else begin
            next_batt = PCS_BATT_GOOD;
        end
    end

    // Registered status; both detects low means a card is seated
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_o <= '0;
        end else begin
            status_o.card_inserted <= !card_present_a_i && !card_present_b_i; // see [RULE3]
            status_o.card_present_a <= card_present_a_i; // see [RULE3]
            status_o.card_present_b <= card_present_b_i;
            status_o.batt <= next_batt;
        end
    end

    // Change pulse, gated per battery condition by the enable bits
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_chg_o <= 1'b0;
        end else begin
            status_chg_o <= (batt_dead_chg_en_i &&
                             ((next_batt == PCS_BATT_DEAD) != (status_o.batt == PCS_BATT_DEAD)))
                         || (batt_weak_chg_en_i &&
                             ((next_batt == PCS_BATT_WEAK) != (status_o.batt == PCS_BATT_WEAK)));
            // see [RULE2]
        end
    end
endmodule

/* File: hdl/pcs_socket_ctrl.sv */
/*
 Socket control for a 16-bit PC Card: byte selects, I/O read and write
 strobes, input acknowledge and DMA reuse of those lines, plus status.

 Each host request runs one card cycle in three phases. Setup drives the
 byte selects low ahead of the strobe so the card can decode the access.
 The strobe phase holds the read or write line low. Hold lets the byte
 selects return high one cycle after the strobe, so the card never sees a
 select released under an active strobe.

 Cycle kinds:
  - I/O read and card-to-host DMA use the read line.
  - I/O write and host-to-card DMA use the write line.
 The card's acknowledge line is watched under the read strobe. In DMA
 mode it is passed on as a DMA request instead of a read acknowledge.

 Requests are taken only from idle and only with a card seated. A request
 raised with no card is simply never taken, and the lines stay high.
 req_ready_o is high exactly while the sequencer is idle, except in reset and the
 first cycle after it, so a host that waits for it with a card seated never
 loses a request. done_o pulses for one cycle as the
 sequencer returns to idle, and a new request may be taken in that cycle.

 Every socket line and handshake output comes from a flip-flop, so the
 pins do not glitch while the sequencer changes phase.

 Limitations: there is no wait-state input, so the card must meet the
 fixed setup and strobe counts of the package. Pulling a card in mid
 cycle does not abort the cycle; it runs to its end on fixed counts.

 Assumes one 40 MHz clock, a synchronous active-high reset, and socket
 inputs already synchronous to the clock.
*/
// Function
// [RULE1] Decode the two battery lines into good, weak or dead.
// [RULE2] Software enable bits gate battery changes onto a status-change pulse.
// [RULE3] Both card detects low means card inserted; report both levels.
// [RULE4] First byte select picks even bytes, second picks odd bytes.
// [RULE5] Card asserts input acknowledge only when it answers the current read.
// [RULE6] A DMA card may use input acknowledge as its DMA request.
// [RULE7] Assert the I/O read strobe during host I/O reads.
// [RULE8] Assert I/O read as the write strobe for card-to-host DMA.
// [RULE9] Drive the I/O write strobe low during host I/O writes.
// [RULE10] Assert I/O write as the strobe for host-to-card DMA.
// [RULE11] Input acknowledge is DMA request only while card DMA is configured.
// [RULE12] Hold byte selects and strobes high when no cycle is running.
`timescale 1ns/1ps
module pcs_socket_ctrl
    import pcs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Host request side
    input wire logic req_valid_i,
    input pcs_req_t req_i,
    input wire logic dma_mode_i,
    output logic req_ready_o,
    output logic done_o,
    output logic input_ack_seen_o,
    output logic dma_request_o,
    // Status and enables
    input wire logic batt_dead_chg_en_i,
    input wire logic batt_weak_chg_en_i,
    output pcs_status_t status_o,
    output logic status_chg_o,
    // Socket pins
    input wire logic battery_detect_a_i,
    input wire logic battery_detect_b_i,
    input wire logic card_present_a_i,
    input wire logic card_present_b_i,
    input wire logic input_ack_n_i,
    output logic even_byte_sel_n_o,
    output logic odd_byte_sel_n_o,
    output logic io_read_strobe_n_o,
    output logic io_write_strobe_n_o
);
    // Sequencer phases; cnt times setup and strobe in clock cycles
    typedef enum logic [1:0] {
        PCS_IDLE,
        PCS_SETUP,
        PCS_STROBE,
        PCS_HOLD
    } pcs_state_t;

    // Sequencer state, the request in flight and the phase counter
    pcs_state_t state;
    pcs_req_t cur; // Latched at take so the host may drop its request
    logic [CNT_W-1:0] cnt;

    // Request taken this cycle: idle, request up and a card seated
    logic take;
    assign take = (state == PCS_IDLE) && req_valid_i && status_o.card_inserted;

    // True when the request moves data card-to-host on the read line
    function automatic logic uses_read_line(input pcs_cyc_t k);
        return (k == PCS_CYC_IO_RD) || (k == PCS_CYC_DMA_TO_HOST);
    endfunction

    // Status decode
    pcs_status u_status (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .battery_detect_a_i(battery_detect_a_i),
        .battery_detect_b_i(battery_detect_b_i),
        .card_present_a_i(card_present_a_i),
        .card_present_b_i(card_present_b_i),
        .batt_dead_chg_en_i(batt_dead_chg_en_i),
        .batt_weak_chg_en_i(batt_weak_chg_en_i),
        .status_o(status_o),
        .status_chg_o(status_chg_o)
    );

    // Cycle sequencer: setup, strobe, hold, back to idle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= PCS_IDLE;
            cur <= '0;
            cnt <= '0;
        end else begin
            unique case (state)
                PCS_IDLE: begin
                    if (take) begin
                        cur <= req_i;
                        cnt <= SETUP_CNT;
                        state <= PCS_SETUP;
                    end
                end
                PCS_SETUP: begin
                    if (cnt <= CNT_W'(1)) begin
                        cnt <= STROBE_CNT;
                        state <= PCS_STROBE;
                    end else begin
                        cnt <= cnt - CNT_W'(1);
                    end
                end
                PCS_STROBE: begin
                    if (cnt <= CNT_W'(1)) begin
                        state <= PCS_HOLD;
                    end else begin
                        cnt <= cnt - CNT_W'(1);
                    end
                end
                PCS_HOLD: begin
                    state <= PCS_IDLE;
                end
            endcase
        end
    end

    // Byte selects span setup, strobe and hold; idle keeps them high
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || state == PCS_HOLD) begin
            even_byte_sel_n_o <= STROBE_IDLE; // see [RULE12]
            odd_byte_sel_n_o <= STROBE_IDLE;
        end else if (take) begin
            even_byte_sel_n_o <= !req_i.even_byte; // see [RULE4]
            odd_byte_sel_n_o <= !req_i.odd_byte; // see [RULE4]
        end
    end

    // Read and write strobes, low only during the strobe phase
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            io_read_strobe_n_o <= STROBE_IDLE;
            io_write_strobe_n_o <= STROBE_IDLE;
        end else if (state == PCS_SETUP && cnt <= CNT_W'(1)) begin
            io_read_strobe_n_o <= !uses_read_line(cur.kind); // see [RULE7] see [RULE8]
            io_write_strobe_n_o <= uses_read_line(cur.kind); // see [RULE9] see [RULE10]
        end else if (state == PCS_STROBE && cnt <= CNT_W'(1)) begin
            io_read_strobe_n_o <= STROBE_IDLE; // see [RULE12]
            io_write_strobe_n_o <= STROBE_IDLE;
        end
    end

    // DMA request: the acknowledge line means a DMA request only in DMA mode.
    // It is passed on one cycle late, whatever phase the sequencer is in.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dma_request_o <= 1'b0;
        end else begin
            dma_request_o <= dma_mode_i && !input_ack_n_i; // see [RULE11] see [RULE6]
        end
    end

    // Read acknowledge: cleared in setup, set when the card answers under the
    // read strobe of an I/O read; it stands until the next cycle's setup.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            input_ack_seen_o <= 1'b0;
        end else if (state == PCS_SETUP) begin
            input_ack_seen_o <= 1'b0;
        end else if (!dma_mode_i && state == PCS_STROBE && cur.kind == PCS_CYC_IO_RD
                     && !input_ack_n_i) begin
            input_ack_seen_o <= 1'b1; // see [RULE11] see [RULE5]
        end
    end

    // Ready: high exactly in the cycles the sequencer sits in idle, except in reset and the first cycle after it, so the
    // cycle that leaves hold already shows ready together with done.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= (state == PCS_HOLD) || (state == PCS_IDLE && !take);
        end
    end

    // Done: one-cycle pulse as the sequencer leaves hold
    // and the byte selects return high.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (state == PCS_HOLD);
        end
    end
endmodule

/* File: testbench/pcs_checker.sv */
/* Port checker for pcs_socket_ctrl.
 Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module pcs_checker
    import pcs_pkg::*;
(
    // Watched ports
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input pcs_req_t req_i,
    input wire logic dma_mode_i,
    input wire logic req_ready_o,
    input wire logic done_o,
    input wire logic dma_request_o,
    input pcs_status_t status_o,
    input wire logic card_present_a_i,
    input wire logic card_present_b_i,
    input wire logic input_ack_n_i,
    input wire logic even_byte_sel_n_o,
    input wire logic odd_byte_sel_n_o,
    input wire logic io_read_strobe_n_o,
    input wire logic io_write_strobe_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    pcs_cyc_t kind;
    wire strobe_n = io_read_strobe_n_o & io_write_strobe_n_o;
    wire take = req_valid_i & req_ready_o & status_o.card_inserted;
    // Kind of the cycle in flight
    always_ff @(posedge clk_sys_i) begin
        if (take) begin
            kind <= req_i.kind;
        end
    end
    sequence walk_s;
        ##4 $fell(strobe_n) ##8 done_o;
    endsequence
    idle_high_a:
        assert property (req_ready_o |-> &{even_byte_sel_n_o, odd_byte_sel_n_o, strobe_n})
        else $error("line low while idle");
    cycle_walk_a:
        assert property (take |-> walk_s) else $error("cycle walk broken");
    strobe_len_a:
        assert property ($fell(strobe_n) |-> !strobe_n [*7] ##1 strobe_n)
        else $error("strobe length wrong");
    byte_sel_a:
        assert property (take |=> even_byte_sel_n_o == !$past(req_i.even_byte)
            && odd_byte_sel_n_o == !$past(req_i.odd_byte)) else $error("byte select wrong");
    read_line_a:
        assert property (!io_read_strobe_n_o |-> kind inside {PCS_CYC_IO_RD, PCS_CYC_DMA_TO_HOST})
        else $error("read strobe on wrong kind");
    write_line_a:
        assert property (!io_write_strobe_n_o |-> kind inside {PCS_CYC_IO_WR, PCS_CYC_DMA_TO_CARD})
        else $error("write strobe on wrong kind");
    card_detect_a:
        assert property (!$past(rst_i) |-> status_o.card_inserted ==
            !($past(card_present_a_i) | $past(card_present_b_i))) else $error("detect wrong");
    dma_req_a:
        assert property (!$past(rst_i) |-> dma_request_o == $past(dma_mode_i & !input_ack_n_i))
        else $error("dma request wrong");
endmodule
bind pcs_socket_ctrl pcs_checker i_chk (.*);

/* File: testbench/pcs_card_model.sv */
/* Card model: detect, battery and input acknowledge lines.
 Assumes the bench sets its wishes at clock edges. */
`timescale 1ns/1ps
module pcs_card_model (
    // From the bench
    input wire logic inserted_i,
    input wire logic [1:0] batt_i,
    input wire logic able_i,
    // Socket side
    input wire logic io_read_strobe_n_i,
    output logic battery_detect_a_o,
    output logic battery_detect_b_o,
    output logic card_present_a_o,
    output logic card_present_b_o,
    output logic input_ack_n_o
);
    // Detect lines grounded on the card, pulled up when absent
    assign card_present_a_o = !inserted_i;
    assign card_present_b_o = !inserted_i;
    // Battery code 0 good, 1 weak, 2 dead
    assign battery_detect_a_o = batt_i != 2'h2;
    assign battery_detect_b_o = batt_i == 2'h0;
    // Answer only under a read strobe; in DMA mode this is the request
    assign input_ack_n_o = !(able_i & !io_read_strobe_n_i);
endmodule

/* File: testbench/testbench.sv */
/* Bench for pcs_socket_ctrl: status corners, refusal, random transfers.
 Assumes the card model drives the socket inputs, one walk per transfer. */
`timescale 1ns/1ps
module testbench;
    import pcs_pkg::*;
    logic clk_sys_i = 0;
    logic rst_i = 1;
    logic req_valid_i = 0;
    pcs_req_t req_i = '0;
    logic dma_mode_i = 0;
    logic [1:0] en = 2'h0;
    logic inserted = 1;
    logic able = 0;
    logic [1:0] batt = 0;
    logic ready, done, seen, chg, bda, bdb, cpa, cpb, ack_n, ev_n, od_n, rd_n, wr_n;
    logic dreq, dseen;
    pcs_status_t st;
    int fails = 0;
    int checks_done = 0;
    int chg_cnt = 0;
    logic [3:0] lo;
    pcs_socket_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .dma_mode_i(dma_mode_i), .req_ready_o(ready), .done_o(done),
        .input_ack_seen_o(seen), .dma_request_o(dreq), .batt_dead_chg_en_i(en[1]),
        .batt_weak_chg_en_i(en[0]), .status_o(st), .status_chg_o(chg),
        .battery_detect_a_i(bda), .battery_detect_b_i(bdb), .card_present_a_i(cpa),
        .card_present_b_i(cpb), .input_ack_n_i(ack_n), .even_byte_sel_n_o(ev_n),
        .odd_byte_sel_n_o(od_n), .io_read_strobe_n_o(rd_n), .io_write_strobe_n_o(wr_n));
    pcs_card_model i_card (.inserted_i(inserted), .batt_i(batt), .able_i(able),
        .io_read_strobe_n_i(rd_n), .battery_detect_a_o(bda), .battery_detect_b_o(bdb),
        .card_present_a_o(cpa), .card_present_b_o(cpb), .input_ack_n_o(ack_n));
    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict
    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Expected lows: read, write, even, odd
    function automatic logic [3:0] exp_lo(input pcs_req_t r);
        return {r.kind == PCS_CYC_IO_RD || r.kind == PCS_CYC_DMA_TO_HOST,
            r.kind == PCS_CYC_IO_WR || r.kind == PCS_CYC_DMA_TO_CARD, r.even_byte, r.odd_byte};
    endfunction
    // Expected change pulses over the walk good, weak, dead, good
    function automatic logic [7:0] exp_chg(input logic [1:0] e);
        logic [7:0] n;
        n = 8'h0;
        for (int b = 1; b < 4; b++) begin
            n += 8'((e[1] && (((b - 1) % 3 == 2) != (b % 3 == 2)))
                || (e[0] && (((b - 1) % 3 == 1) != (b % 3 == 1))));
        end
        return n;
    endfunction
    // One card cycle, watched until done
    task automatic xfer(input pcs_req_t r, input logic a);
        int n;
        n = 0;
        lo = 4'h0;
        dseen = 1'b0;
        @(posedge clk_sys_i);
        req_valid_i <= 1;
        req_i <= r;
        dma_mode_i <= r.kind[1];
        able <= a;
        do @(posedge clk_sys_i); while (ready !== 1'b1);
        req_valid_i <= 0;
        do begin
            @(negedge clk_sys_i);
            n++;
            lo |= ~{rd_n, wr_n, ev_n, od_n};
            dseen |= dreq;
        end while (done !== 1'b1 && n < 20);
        check(8'(n), 8'(SETUP_CYC + STROBE_CYC + 2));
        check(8'(lo), 8'(exp_lo(r)));
        check(8'(seen), 8'(a && r.kind == PCS_CYC_IO_RD));
        check(8'(dseen), 8'(a && r.kind == PCS_CYC_DMA_TO_HOST));
    endtask
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Status-change pulses
    always @(negedge clk_sys_i) begin
        if (chg === 1'b1) begin
            chg_cnt++;
        end
    end
    // Watchdog
    initial begin
        #40000;
        fails++;
        results();
    end
    initial begin
        void'($urandom(63125));
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 0;
        // Battery codes with change enables off, then on
        for (int e = 0; e < 4; e++) begin
            chg_cnt = 0;
            for (int b = 0; b < 4; b++) begin
                @(posedge clk_sys_i);
                en <= 2'(e);
                batt <= 2'(b % 3);
                repeat (3) @(negedge clk_sys_i);
                check(8'(st.batt), 8'(b % 3));
            end
            check(8'(chg_cnt), exp_chg(2'(e)));
        end
        // No card: request refused and lines stay high
        @(posedge clk_sys_i);
        inserted <= 0;
        repeat (2) @(posedge clk_sys_i);
        req_valid_i <= 1;
        lo = 4'hf;
        repeat (15) begin
            @(negedge clk_sys_i);
            lo &= {rd_n, wr_n, ev_n, od_n};
        end
        check(8'({st.card_inserted, st.card_present_a, st.card_present_b, lo}), 8'h3f);
        @(posedge clk_sys_i);
        req_valid_i <= 0;
        inserted <= 1;
        repeat (2) @(posedge clk_sys_i);
        // Every kind first, then random
        for (int i = 0; i < 40; i++) begin
            xfer(i < 4 ? pcs_req_t'({2'(i), 2'h3}) : pcs_req_t'(4'($urandom)), 1'($urandom));
        end
        results();
    end
endmodule
